// ==== design/pilp_pkg.sv ====
/*
  Package for the prioritized interrupt and low-power controller.
  Holds vectors, priority indices, register field positions, reset values and timing counts.
  Assumes a single 100 MHz processor cycle clock.
*/
package pilp_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] OFF_MASK       = 4'h0;
  localparam logic [3:0] OFF_CTRL       = 4'h1;
  localparam logic [3:0] OFF_FORCE_CLR  = 4'h2;
  localparam logic [3:0] OFF_PEND       = 4'h3;
  localparam logic [3:0] OFF_STATUS     = 4'h4;
  localparam logic [3:0] OFF_LOWPOWER   = 4'h5;
  localparam logic [3:0] OFF_STACK_TOP  = 4'h6;

  // Source count and priority index, 0 = highest maskable (power-down is separate)
  localparam int NUM_SRC = 10;
  localparam int SRC_CFG   = 0;
  localparam int SRC_LVLB  = 1;
  localparam int SRC_LVLA  = 2;
  localparam int SRC_SPA_TX = 3;
  localparam int SRC_SPA_RX = 4;
  localparam int SRC_EDGE  = 5;
  localparam int SRC_BYTE_DMA_PORT  = 6;
  localparam int SRC_ALTB  = 7;
  localparam int SRC_ALTA  = 8;
  localparam int SRC_TIMER = 9;

  // Vector addresses
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_PWD   = 16'h002C;
  localparam logic [15:0] VEC_CFG   = 16'h0004;
  localparam logic [15:0] VEC_LVLB  = 16'h0008;
  localparam logic [15:0] VEC_LVLA  = 16'h000C;
  localparam logic [15:0] VEC_SPATX = 16'h0010;
  localparam logic [15:0] VEC_SPARX = 16'h0014;
  localparam logic [15:0] VEC_EDGE  = 16'h0018;
  localparam logic [15:0] VEC_BYTE_DMA_PORT  = 16'h001C;
  localparam logic [15:0] VEC_ALTB  = 16'h0020;
  localparam logic [15:0] VEC_ALTA  = 16'h0024;
  localparam logic [15:0] VEC_TIMER = 16'h0028;

  // Control register fields
  localparam int CTRL_SENSE_ALTA = 0;   // 1 = edge
  localparam int CTRL_SENSE_ALTB = 1;
  localparam int CTRL_SENSE_CFG  = 2;
  localparam int CTRL_NEST       = 4;   // 1 = nested
  localparam int CTRL_SPB_ALT    = 5;   // serial port B as request pins
  localparam int CTRL_CYCLE_CLOCK_OUT_DIS = 6;
  localparam int CTRL_POWERUP_CONTEXT_BIT       = 7;   // context clear on power-up
  localparam int CTRL_OSC_OFF    = 8;   // oscillator stopped in power-down
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [9:0] MASK_RESET = 10'h000;

  // Force/clear word: [9:0] force, [19:10] clear, bit 20 power-down force
  localparam int FC_CLR_LSB = 10;
  localparam int FC_PWD_FORCE = 20;

  // Low-power command word: [1:0] kind, [3:2] divisor code
  localparam logic [1:0] LP_NONE = 2'h0;
  localparam logic [1:0] LP_IDLE = 2'h1;
  localparam logic [1:0] LP_PWD  = 2'h2;

  localparam int STACK_DEPTH = 12;

  // Timing: input clock is half the cycle clock
  localparam int CLK_MHZ           = 100;
  localparam int INPUT_CLOCK_PER_CYCLE_X2 = 1;   // one input clock = two cycles
  localparam int WAKE_FAST_INPUT_CLOCK   = 200;
  localparam int WAKE_SLOW_INPUT_CLOCK   = 4096;
  localparam int WAKE_FAST_CYC     = WAKE_FAST_INPUT_CLOCK * 2 * INPUT_CLOCK_PER_CYCLE_X2;
  localparam int WAKE_SLOW_CYC     = WAKE_SLOW_INPUT_CLOCK * 2 * INPUT_CLOCK_PER_CYCLE_X2;
endpackage : pilp_pkg

// ==== design/pilp_ctrl.sv ====
/*
  Prioritized interrupt controller with power-down, idle and slow-idle sequencing.
  Assumes request pins are synchronous, active high inside the core, and that the
  sequencer issues one-cycle instruction strobes (take, return, idle, enable, disable).
*/
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module pilp_ctrl #(
  parameter int WAKE_FAST = pilp_pkg::WAKE_FAST_CYC,
  parameter int WAKE_SLOW = pilp_pkg::WAKE_SLOW_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [20:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [20:0] reg_rdata_o,
  input  wire logic        config_sense_req_pin_i,
  input  wire logic        level_req_pin_a_i,
  input  wire logic        level_req_pin_b_i,
  input  wire logic        edge_req_pin_i,
  input  wire logic        alt_req_pin_a_i,
  input  wire logic        alt_req_pin_b_i,
  input  wire logic        serial_port_a_tx_i,
  input  wire logic        serial_port_a_rx_i,
  input  wire logic        serial_port_b_tx_i,
  input  wire logic        serial_port_b_rx_i,
  input  wire logic        byte_dma_port_i,
  input  wire logic        timer_i,
  input  wire logic        powerdown_request_pin_i,
  output logic             powerdown_ack_pin_o,
  input  wire logic        take_i,
  input  wire logic        rti_i,
  input  wire logic        global_int_enable_instr_i,
  input  wire logic        global_int_disable_instr_i,
  input  wire logic        push_i,
  input  wire logic        pop_i,
  input  wire logic [15:0] status_i,
  input  wire logic [1:0]  lp_cmd_i,
  input  wire logic [1:0]  lp_div_i,
  input  wire logic        lp_div_valid_i,
  input  wire logic        steal_req_i,
  output logic             steal_gnt_o,
  output logic             irq_o,
  output logic      [15:0] vector_o,
  output logic      [15:0] stack_top_o,
  output logic             stack_ovf_o,
  output logic             cycle_en_o,
  output logic             cycle_clock_out_o,
  output logic             context_clear_o,
  output logic             run_o
);
  typedef enum logic [1:0] {PILP_RUN, PILP_IDLE, PILP_DOWN, PILP_WAKE} pilp_state_t;

  // Reset synchroniser; first flop read only by the second
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  // Priority encoder, used for both pending and in-service selection
  function automatic logic [3:0] pilp_first(input logic [9:0] v);
    pilp_first = 4'hF;
    for (int i = pilp_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) pilp_first = 4'(i);
    end
  endfunction : pilp_first

  function automatic logic [15:0] pilp_vec(input logic [3:0] idx);
    case (idx)
      4'h0:    pilp_vec = pilp_pkg::VEC_CFG;
      4'h1:    pilp_vec = pilp_pkg::VEC_LVLB;
      4'h2:    pilp_vec = pilp_pkg::VEC_LVLA;
      4'h3:    pilp_vec = pilp_pkg::VEC_SPATX;
      4'h4:    pilp_vec = pilp_pkg::VEC_SPARX;
      4'h5:    pilp_vec = pilp_pkg::VEC_EDGE;
      4'h6:    pilp_vec = pilp_pkg::VEC_BYTE_DMA_PORT;
      4'h7:    pilp_vec = pilp_pkg::VEC_ALTB;
      4'h8:    pilp_vec = pilp_pkg::VEC_ALTA;
      default: pilp_vec = pilp_pkg::VEC_TIMER;
    endcase
  endfunction : pilp_vec

  logic [9:0]  mask_q, edge_pend_q, insvc_q, raw_prev_q, force_q;
  logic [8:0]  ctrl_q;
  logic        gie_q, mask_hold_q, pwd_pend_q, pwd_prev_q, pwd_insvc_q;
  logic [15:0] stk_q [pilp_pkg::STACK_DEPTH];
  logic [3:0]  sp_q;
  logic        ovf_q;
  pilp_state_t st_q;
  logic [13:0] wake_cnt_q;
  logic [7:0]  div_cnt_q, div_n_q;
  logic        clk_div_q;
  logic [20:0] rdata_q;

  // Register decode
  wire wr_mask = reg_wr_i && (reg_addr_i == pilp_pkg::OFF_MASK);
  wire wr_ctrl = reg_wr_i && (reg_addr_i == pilp_pkg::OFF_CTRL);
  wire wr_fc   = reg_wr_i && (reg_addr_i == pilp_pkg::OFF_FORCE_CLR);
  wire [9:0] fc_set = wr_fc ? reg_wdata_i[9:0] : 10'h000;
  wire [9:0] fc_clr = wr_fc ? reg_wdata_i[pilp_pkg::FC_CLR_LSB +: 10] : 10'h000;
  wire sw_pwd  = wr_fc && reg_wdata_i[pilp_pkg::FC_PWD_FORCE];

  // Raw requests; serial port B lines turn into request pins when reconfigured
  wire spb_alt = ctrl_q[pilp_pkg::CTRL_SPB_ALT];
  wire [9:0] raw;
  assign raw[pilp_pkg::SRC_CFG]    = config_sense_req_pin_i;
  assign raw[pilp_pkg::SRC_LVLB]   = level_req_pin_b_i;
  assign raw[pilp_pkg::SRC_LVLA]   = level_req_pin_a_i;
  assign raw[pilp_pkg::SRC_SPA_TX] = serial_port_a_tx_i;
  assign raw[pilp_pkg::SRC_SPA_RX] = serial_port_a_rx_i;
  assign raw[pilp_pkg::SRC_EDGE]   = edge_req_pin_i;
  assign raw[pilp_pkg::SRC_BYTE_DMA_PORT]   = byte_dma_port_i;
  assign raw[pilp_pkg::SRC_ALTB]   = spb_alt ? alt_req_pin_b_i : serial_port_b_tx_i;
  assign raw[pilp_pkg::SRC_ALTA]   = spb_alt ? alt_req_pin_a_i : serial_port_b_rx_i;
  assign raw[pilp_pkg::SRC_TIMER]  = timer_i;

  // Sense per source: fixed for level/edge pins and on-chip sources, selectable for the three others
  wire [9:0] is_edge;
  assign is_edge[0]   = ctrl_q[pilp_pkg::CTRL_SENSE_CFG];
  assign is_edge[2:1] = 2'b00;
  assign is_edge[4:3] = 2'b11;
  assign is_edge[5]   = 1'b1;
  assign is_edge[6]   = 1'b1;
  assign is_edge[7]   = spb_alt ? ctrl_q[pilp_pkg::CTRL_SENSE_ALTB] : 1'b1;
  assign is_edge[8]   = spb_alt ? ctrl_q[pilp_pkg::CTRL_SENSE_ALTA] : 1'b1;
  assign is_edge[9]   = 1'b1;

  wire [9:0] rise    = raw & ~raw_prev_q;
  wire [9:0] pending = (edge_pend_q | (raw & ~is_edge) | force_q);
  wire [9:0] unmasked = pending & mask_q & {10{~mask_hold_q}};
  wire [3:0] best     = pilp_first(unmasked);
  wire [3:0] cur      = pilp_first(insvc_q);
  wire nest = ctrl_q[pilp_pkg::CTRL_NEST];
  wire any_svc = (|insvc_q) || pwd_insvc_q;
  wire can_take = nest ? (best < cur) && !pwd_insvc_q : !any_svc;
  wire pwd_req  = pwd_pend_q && !pwd_insvc_q;
  wire mask_req = (best != 4'hF) && can_take;
  wire irq_d    = gie_q && (st_q != PILP_DOWN) && (st_q != PILP_WAKE)
                  && (pwd_req || mask_req);
  wire [15:0] vec_d = pwd_req ? pilp_pkg::VEC_PWD : pilp_vec(best);
  wire take_m = take_i && irq_d && !pwd_req;
  wire [9:0] take_bit = take_m ? (10'h001 << best) : 10'h000;
  wire [9:0] ret_bit  = (rti_i && !pwd_insvc_q) ? (10'h001 << cur) : 10'h000;

  // Mask, control, global enable and the one-cycle hold after a mask write
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mask_q      <= pilp_pkg::MASK_RESET;
      ctrl_q      <= pilp_pkg::CTRL_RESET;
      mask_hold_q <= 1'b0;
      gie_q       <= 1'b1;
    end else begin
      if (wr_mask) mask_q <= reg_wdata_i[9:0];
      if (wr_ctrl) ctrl_q <= reg_wdata_i[8:0];
      mask_hold_q <= wr_mask;
      if (global_int_disable_instr_i) gie_q <= 1'b0;
      else if (global_int_enable_instr_i) gie_q <= 1'b1;
    end
  end

  // Edge latches and forced bits; a new edge or force beats a same-cycle clear
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      edge_pend_q <= 10'h000;
      force_q     <= 10'h000;
      raw_prev_q  <= 10'h000;
      insvc_q     <= 10'h000;
    end else begin
      raw_prev_q  <= raw;
      edge_pend_q <= ((edge_pend_q & ~fc_clr & ~take_bit) | (rise & is_edge));
      force_q     <= ((force_q & ~fc_clr & ~take_bit) | fc_set);
      insvc_q     <= (insvc_q & ~ret_bit) | take_bit;
    end
  end

  // Power-down interrupt: edge of pin or software force
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pwd_prev_q  <= 1'b0;
      pwd_pend_q  <= 1'b0;
      pwd_insvc_q <= 1'b0;
    end else begin
      pwd_prev_q <= powerdown_request_pin_i;
      if ((powerdown_request_pin_i && !pwd_prev_q) || sw_pwd) pwd_pend_q <= 1'b1;
      else if (take_i && pwd_req && gie_q) pwd_pend_q <= 1'b0;
      if (take_i && pwd_req && irq_d) pwd_insvc_q <= 1'b1;
      else if (rti_i && pwd_insvc_q) pwd_insvc_q <= 1'b0;
    end
  end

  // Status stack, twelve deep, shared by interrupts, loops and calls
  wire push_any = push_i || (take_i && irq_d);
  wire pop_any  = pop_i || rti_i;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sp_q  <= 4'h0;
      ovf_q <= 1'b0;
    end else if (push_any && !pop_any) begin
      if (sp_q == 4'(pilp_pkg::STACK_DEPTH)) ovf_q <= 1'b1;
      else sp_q <= sp_q + 4'h1;
    end else if (pop_any && !push_any && sp_q != 4'h0) begin
      sp_q <= sp_q - 4'h1;
    end
  end
  // Stack storage has no reset; pointer alone defines contents
  always_ff @(posedge mclk_i) begin
    if (push_any && !pop_any && sp_q < 4'(pilp_pkg::STACK_DEPTH)) stk_q[sp_q] <= status_i;
  end

  // Low-power sequencer
  wire wake_any = (|(pending & mask_q)) || pwd_pend_q;
  wire div_tick = (div_cnt_q == 8'h00);
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= PILP_RUN;
      wake_cnt_q <= 14'h0000;
      div_n_q    <= 8'h00;
      div_cnt_q  <= 8'h00;
    end else begin
      div_cnt_q <= div_tick ? div_n_q : div_cnt_q - 8'h01;
      case (st_q)
        PILP_RUN: begin
          if (lp_cmd_i == pilp_pkg::LP_IDLE) begin
            st_q    <= PILP_IDLE;
            div_n_q <= lp_div_valid_i ? (8'h0F << lp_div_i) | 8'h0F : 8'h00;
          end else if (lp_cmd_i == pilp_pkg::LP_PWD) begin
            st_q <= PILP_DOWN;
          end
        end
        PILP_IDLE: begin
          if (wake_any && div_tick) begin
            st_q      <= PILP_RUN;
            div_n_q   <= 8'h00;
            div_cnt_q <= 8'h00;                  // Stale count would stall run clock
          end
        end
        PILP_DOWN: begin
          if (pwd_pend_q || (powerdown_request_pin_i && !pwd_prev_q)) begin
            st_q       <= PILP_WAKE;
            wake_cnt_q <= ctrl_q[pilp_pkg::CTRL_OSC_OFF] ? 14'(WAKE_SLOW - 1)
                                                         : 14'(WAKE_FAST - 1);
          end
        end
        PILP_WAKE: begin
          if (wake_cnt_q == 14'h0000) st_q <= PILP_RUN;
          else wake_cnt_q <= wake_cnt_q - 14'h0001;
        end
        default: st_q <= PILP_RUN;
      endcase
    end
  end

  // Cycle clock output divided alongside slow idle, gateable
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) clk_div_q <= 1'b0;
    else if (div_tick) clk_div_q <= ~clk_div_q;
  end

  // Read data one cycle after strobe; force/clear reads as zero
  wire [20:0] rd_mux =
    (reg_addr_i == pilp_pkg::OFF_MASK)      ? {11'h000, mask_q} :
    (reg_addr_i == pilp_pkg::OFF_CTRL)      ? {12'h000, ctrl_q} :
    (reg_addr_i == pilp_pkg::OFF_PEND)      ? {10'h000, pwd_pend_q, pending} :
    (reg_addr_i == pilp_pkg::OFF_STATUS)    ? {10'h000, pwd_insvc_q, insvc_q} :
    (reg_addr_i == pilp_pkg::OFF_LOWPOWER)  ? {13'h0000, ovf_q, sp_q, gie_q, st_q} :
    (reg_addr_i == pilp_pkg::OFF_STACK_TOP) ? {5'h00, stack_top_o} :
                                              21'h000000;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) rdata_q <= 21'h000000;
    else rdata_q <= reg_rd_i ? rd_mux : 21'h000000;
  end

  // Outputs
  assign reg_rdata_o         = rdata_q;
  assign irq_o               = irq_d;
  assign vector_o            = vec_d;
  assign stack_top_o         = (sp_q == 4'h0) ? 16'h0000 : stk_q[sp_q - 4'h1];
  assign stack_ovf_o         = ovf_q;
  assign powerdown_ack_pin_o = (st_q == PILP_DOWN);
  assign run_o               = (st_q == PILP_RUN);
  assign cycle_en_o          = (st_q == PILP_RUN) || ((st_q == PILP_IDLE) && div_tick);
  assign cycle_clock_out_o   = ~ctrl_q[pilp_pkg::CTRL_CYCLE_CLOCK_OUT_DIS] && clk_div_q;
  assign context_clear_o     = (st_q == PILP_WAKE) && (wake_cnt_q == 14'h0000)
                               && ctrl_q[pilp_pkg::CTRL_POWERUP_CONTEXT_BIT];
  assign steal_gnt_o         = steal_req_i && (st_q != PILP_DOWN);
endmodule : pilp_ctrl

// ==== dv/pilp_ctrl_sva.sv ====
/* Port checker for pilp_ctrl, bound to every instance below.
   Assumes one clock domain; the reset pin disables every property. */
`timescale 1ns/1ps
module pilp_ctrl_sva (
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [20:0] reg_rdata_o,
  input wire logic        powerdown_ack_pin_o,
  input wire logic        take_i,
  input wire logic        global_int_disable_instr_i,
  input wire logic        steal_req_i,
  input wire logic        steal_gnt_o,
  input wire logic        irq_o,
  input wire logic [15:0] vector_o,
  input wire logic        stack_ovf_o,
  input wire logic        context_clear_o,
  input wire logic        run_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);

  // Request path against mask writes, global disable and the vector table
  a_mask_wr_block: assert property (reg_wr_i && reg_addr_i == pilp_pkg::OFF_MASK |=> !irq_o)
    else $error("request seen right after a mask write");
  a_dis_blocks: assert property (global_int_disable_instr_i |=> !irq_o [*2])
    else $error("request seen after global disable");
  a_vector_legal: assert property (irq_o |-> vector_o[1:0] == 2'h0 &&
    vector_o inside {[pilp_pkg::VEC_CFG:pilp_pkg::VEC_PWD]})
    else $error("vector outside the table");

  // Register port: write-only word and idle read data
  a_fc_read_zero: assert property (reg_rd_i && reg_addr_i == pilp_pkg::OFF_FORCE_CLR
    |=> reg_rdata_o == 21'h000000)
    else $error("force word read back non-zero");
  a_rd_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 21'h000000)
    else $error("read data outside its cycle");

  // Low-power state against grants and run, context clear and the sticky overflow flag
  a_ack_not_run: assert property (powerdown_ack_pin_o |-> !run_o && !steal_gnt_o)
    else $error("running or granting while powered down");
  a_steal_grant: assert property (steal_req_i && !powerdown_ack_pin_o |-> steal_gnt_o)
    else $error("cycle steal refused outside power-down");
  a_ovf_sticky: assert property (stack_ovf_o |=> stack_ovf_o)
    else $error("stack overflow flag dropped");
  a_ctx_pulse: assert property (context_clear_o |=> !context_clear_o)
    else $error("context clear longer than one cycle");
  a_ctx_then_run: assert property (context_clear_o |=> run_o)
    else $error("context clear not followed by run");

  c_take: cover property (irq_o && take_i);
  c_down: cover property (powerdown_ack_pin_o);
  c_ovf: cover property (stack_ovf_o);
  c_ctx: cover property (context_clear_o);
endmodule : pilp_ctrl_sva

bind pilp_ctrl pilp_ctrl_sva u_pilp_ctrl_sva (.mclk_i, .nrst_i, .reg_addr_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .powerdown_ack_pin_o, .take_i, .global_int_disable_instr_i,
  .steal_req_i, .steal_gnt_o, .irq_o, .vector_o, .stack_ovf_o, .context_clear_o, .run_o);

// ==== dv/pilp_src_model.sv ====
/* External request sources and power-down control beside the controller.
   Assumes callers run the tasks from one process at a time. */
`timescale 1ns/1ps
module pilp_src_model (
  input  wire logic       mclk_i,
  output logic      [5:0] pins_o,
  output logic            pd_pin_o
);
  initial begin
    pins_o   = 6'h00;
    pd_pin_o = 1'h0;
  end

  // Level request; pin holds until told otherwise
  task automatic set_pin(input int k, input logic v);
    @(posedge mclk_i);
    pins_o[k] <= v;
  endtask : set_pin

  // Short pulse, long enough for the edge detector
  task automatic pulse_pin(input int k);
    set_pin(k, 1'h1);
    repeat (2) @(posedge mclk_i);
    pins_o[k] <= 1'h0;
  endtask : pulse_pin

  // Power-down event is a rising edge, then the pin drops again
  task automatic pd_pulse();
    @(posedge mclk_i);
    pd_pin_o <= 1'h1;
    repeat (3) @(posedge mclk_i);
    pd_pin_o <= 1'h0;
  endtask : pd_pulse
endmodule : pilp_src_model

// ==== dv/pilp_ctrl_test.sv ====
/* Self-checking bench: a source table, then hand-written cases.
   Assumes the source model drives the pins and the bench plays the sequencer. */
`timescale 1ns/1ps
module pilp_ctrl_test;
  localparam int WF = 4;
  localparam int WS = 8;
  logic        mclk_i, nrst_i, reg_wr_i, reg_rd_i, steal_req_i, c0;
  logic [3:0]  reg_addr_i;
  logic [20:0] reg_wdata_i, reg_rdata_o, d;
  logic [9:0]  iv;
  logic [5:0]  pins, st;
  logic [15:0] status_i, vector_o, stack_top_o;
  logic [1:0]  lp_cmd_i;
  logic        pd, ack, gnt, irq_o, ovf, cen, clko, ctx, run_o, slow;
  int          error_cnt, total_checks, n, nw[2];
  logic [15:0] vt[10] = '{pilp_pkg::VEC_CFG, pilp_pkg::VEC_LVLB, pilp_pkg::VEC_LVLA,
    pilp_pkg::VEC_SPATX, pilp_pkg::VEC_SPARX, pilp_pkg::VEC_EDGE, pilp_pkg::VEC_BYTE_DMA_PORT,
    pilp_pkg::VEC_ALTB, pilp_pkg::VEC_ALTA, pilp_pkg::VEC_TIMER};

  pilp_ctrl #(.WAKE_FAST(WF), .WAKE_SLOW(WS)) u_pilp_ctrl (.mclk_i, .nrst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .config_sense_req_pin_i(pins[0]),
    .level_req_pin_b_i(pins[1]), .level_req_pin_a_i(pins[2]), .edge_req_pin_i(pins[3]),
    .alt_req_pin_b_i(pins[4]), .alt_req_pin_a_i(pins[5]), .serial_port_a_tx_i(iv[3]),
    .serial_port_a_rx_i(iv[4]), .byte_dma_port_i(iv[6]), .serial_port_b_tx_i(iv[7]),
    .serial_port_b_rx_i(iv[8]), .timer_i(iv[9]), .powerdown_request_pin_i(pd),
    .powerdown_ack_pin_o(ack), .take_i(st[0]), .rti_i(st[1]), .global_int_enable_instr_i(st[2]),
    .global_int_disable_instr_i(st[3]), .push_i(st[4]), .pop_i(st[5]), .status_i, .lp_cmd_i,
    .lp_div_i(2'h0), .lp_div_valid_i(slow), .steal_req_i, .steal_gnt_o(gnt), .irq_o,
    .vector_o, .stack_top_o, .stack_ovf_o(ovf), .cycle_en_o(cen), .cycle_clock_out_o(clko),
    .context_clear_o(ctx), .run_o);
  pilp_src_model u_pilp_src_model (.mclk_i, .pins_o(pins), .pd_pin_o(pd));

  initial begin
    mclk_i = 1'h0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // Register port cycles; each ends settled in the cycle after the strobe
  task automatic wr(input logic [3:0] a, input logic [20:0] v);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'h1;
    @(posedge mclk_i);
    reg_wr_i    <= 1'h0;
    @(negedge mclk_i);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'h1;
    @(posedge mclk_i);
    reg_rd_i   <= 1'h0;
    @(negedge mclk_i);
    d = reg_rdata_o;
  endtask : rd

  // Sequencer strobes 0..5; 6 and 7 are the idle and power-down commands
  task automatic strobe(input int k, input logic [15:0] v);
    @(posedge mclk_i);
    status_i <= v;
    if (k > 5) lp_cmd_i <= 2'(k - 5);
    else st[k] <= 1'h1;
    @(posedge mclk_i);
    st       <= 6'h00;
    lp_cmd_i <= 2'h0;
    @(negedge mclk_i);
  endtask : strobe

  // Pins go through the source model, on-chip sources straight in
  task automatic src(input int i, input logic v);
    if (i < 3) u_pilp_src_model.set_pin(i, v);
    else if (i == 5) u_pilp_src_model.set_pin(3, v);
    else begin
      @(posedge mclk_i);
      iv[i] <= v;
    end
  endtask : src

  // Bounded wait on run (w=0) or acknowledge (w=1); a timeout ends the run
  task automatic wait_sig(input bit w, input logic v);
    for (n = 0; n < 60 && (w ? ack : run_o) !== v; n++) @(negedge mclk_i);
    chk(w ? "ack" : "run", 32'(v), 32'(w ? ack : run_o));
    if (n == 60) complete_run();
  endtask : wait_sig

  task automatic do_reset();
    @(posedge mclk_i);
    nrst_i <= 1'h0;
    @(negedge mclk_i);
    chk("ack in reset", 1'h0, ack);
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'h1;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : do_reset

  initial begin
    {nrst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, iv, st, status_i, lp_cmd_i,
      steal_req_i, slow} = '0;
    do_reset();
    chk("irq", 1'h0, irq_o);
    rd(pilp_pkg::OFF_MASK);
    chk("mask", 21'(pilp_pkg::MASK_RESET), d);
    rd(4'hF);
    chk("unmapped", 21'h000000, d);
    // One row per source: raise, expect its vector, drop and clear
    for (int i = 0; i < 10; i++) begin
      wr(pilp_pkg::OFF_MASK, 21'(1 << i));
      src(i, 1'h1);
      repeat (2) @(negedge mclk_i); // Edge sources latch one cycle later
      chk("vector", vt[i], irq_o ? vector_o : 16'hFFFF);
      src(i, 1'h0);
      wr(pilp_pkg::OFF_FORCE_CLR, 21'(1 << (i + 10)));
      chk("cleared", 1'h0, irq_o);
    end
    $display("test table done");
    // Priority, masking, the blind cycle and global gating
    wr(pilp_pkg::OFF_MASK, 21'h0003FF);
    src(9, 1'h1);
    src(3, 1'h1);
    src(2, 1'h1);
    @(negedge mclk_i);
    chk("top", pilp_pkg::VEC_LVLA, vector_o);
    wr(pilp_pkg::OFF_MASK, 21'h0003FB);
    chk("blind", 1'h0, irq_o);
    @(negedge mclk_i);
    chk("next", pilp_pkg::VEC_SPATX, vector_o);
    strobe(3, 16'h0000);
    chk("disabled", 1'h0, irq_o);
    strobe(2, 16'h0000);
    chk("enabled", 1'h1, irq_o);
    iv <= 10'h000;
    src(2, 1'h0);
    wr(pilp_pkg::OFF_FORCE_CLR, 21'h0FFC00);
    $display("test priority done");
    // Serial port B as two pins, level sensed
    wr(pilp_pkg::OFF_CTRL, 21'h000020);
    wr(pilp_pkg::OFF_MASK, 21'h000180);
    u_pilp_src_model.set_pin(5, 1'h1);
    u_pilp_src_model.set_pin(4, 1'h1);
    @(negedge mclk_i);
    chk("alt b", pilp_pkg::VEC_ALTB, vector_o);
    u_pilp_src_model.set_pin(4, 1'h0);
    @(negedge mclk_i);
    chk("alt a", pilp_pkg::VEC_ALTA, vector_o);
    u_pilp_src_model.set_pin(5, 1'h0);
    @(negedge mclk_i);
    chk("alt off", 1'h0, irq_o);
    // Edge latching, force and clear
    wr(pilp_pkg::OFF_CTRL, 21'h000004);
    wr(pilp_pkg::OFF_MASK, 21'h000021);
    u_pilp_src_model.pulse_pin(3);
    @(negedge mclk_i);
    chk("edge held", pilp_pkg::VEC_EDGE, irq_o ? vector_o : 16'hFFFF);
    u_pilp_src_model.pulse_pin(0);
    @(negedge mclk_i);
    chk("cfg edge", pilp_pkg::VEC_CFG, vector_o);
    wr(pilp_pkg::OFF_FORCE_CLR, 21'h008400);
    chk("clear", 1'h0, irq_o);
    wr(pilp_pkg::OFF_FORCE_CLR, 21'h000020);
    chk("force", 1'h1, irq_o);
    rd(pilp_pkg::OFF_FORCE_CLR);
    chk("fc read", 21'h000000, d);
    wr(pilp_pkg::OFF_FORCE_CLR, 21'h008000);
    $display("test edge done");
    // Nesting: a higher edge request preempts the timer only when nested
    for (int m = 0; m < 2; m++) begin
      wr(pilp_pkg::OFF_CTRL, 21'(m << 4));
      wr(pilp_pkg::OFF_MASK, 21'h000220);
      src(9, 1'h1);
      strobe(0, 16'h0000);
      src(5, 1'h1);
      repeat (2) @(negedge mclk_i);
      chk("nest", 32'(m), irq_o);
      src(9, 1'h0);
      src(5, 1'h0);
      strobe(1, 16'h0000);
      wr(pilp_pkg::OFF_FORCE_CLR, 21'h0FFC00);
    end
    $display("test nest done");
    // Status stack: twelve fit, the thirteenth overflows
    for (int k = 1; k < 13; k++) strobe(4, 16'(k));
    chk("top12", 16'h000C, stack_top_o);
    chk("no ovf", 1'h0, ovf);
    strobe(5, 16'h0000);
    chk("top11", 16'h000B, stack_top_o);
    strobe(4, 16'h000C);
    strobe(4, 16'h000D);
    chk("ovf", 1'h1, ovf);
    for (int k = 0; k < 12; k++) strobe(5, 16'h0000);
    // Idle: steals granted, unmasked request wakes
    wr(pilp_pkg::OFF_MASK, 21'h000200);
    // Slow idle by sixteen first, then plain idle
    for (int s = 1; s >= 0; s--) begin
      slow = 1'(s);
      strobe(6, 16'h0000);
      chk("idle", 1'h0, run_o);
      steal_req_i <= 1'h1;
      @(negedge mclk_i);
      chk("steal", 1'h1, gnt);
      chk("idle clock", 32'(s == 0), cen);
      src(9, 1'h1);
      wait_sig(0, 1'h1);
      chk("idle exit", 1'h1, 32'(n <= (s ? 18 : 3)));
      strobe(0, 16'h0000);
      src(9, 1'h0);
      strobe(1, 16'h0000);
    end
    // Cycle clock output toggles when enabled, frozen when disabled
    c0 = clko;
    @(negedge mclk_i);
    chk("cycle clock on", 32'(!c0), clko);
    wr(pilp_pkg::OFF_CTRL, 21'h000040);
    c0 = clko;
    repeat (8) @(negedge mclk_i) chk("cycle clock", c0, clko);
    $display("test idle done");
    // Power-down by pin then by force bit, oscillator kept then stopped
    wr(pilp_pkg::OFF_MASK, 21'h000000);
    for (int o = 0; o < 2; o++) begin
      wr(pilp_pkg::OFF_CTRL, 21'(o * 9'h180)); // Second pass: oscillator off, clean context
      if (o == 0) u_pilp_src_model.pd_pulse();
      else wr(pilp_pkg::OFF_FORCE_CLR, 21'h100000);
      @(negedge mclk_i);
      chk("pd vector", pilp_pkg::VEC_PWD, irq_o ? vector_o : 16'hFFFF);
      strobe(0, 16'h0000);
      strobe(7, 16'h0000);
      wait_sig(1, 1'h1);
      chk("no steal", 1'h0, gnt);
      u_pilp_src_model.pd_pulse();
      wait_sig(0, 1'h1);
      nw[o] = n;
      strobe(1, 16'h0000);
    end
    chk("fast wake", WF - 1, nw[0]);
    chk("slow wake", WS - 1, nw[1]);
    // Reset ends power-down and clears the stack flag
    u_pilp_src_model.pd_pulse();
    strobe(0, 16'h0000);
    strobe(7, 16'h0000);
    wait_sig(1, 1'h1);
    do_reset();
    chk("run", 1'h1, run_o);
    chk("ovf reset", 1'h0, ovf);
    $display("test power-down done");
    complete_run();
  end
endmodule : pilp_ctrl_test
